// file: src/rsl_map.vh
/*
  register offsets, field positions, reset values and decode codes of the
  reset strap latch.
  assumes: included by the strap latch design files only.
*/
`ifndef RSL_MAP_VH
`define RSL_MAP_VH

// apb register byte offsets
`define RSL_OFF_STATION   12'h000
`define RSL_OFF_MODE      12'h004
`define RSL_OFF_ADV       12'h008
`define RSL_OFF_STATUS    12'h00c

// station control register fields
`define RSL_ADDR_W        5
`define RSL_ISO_BIT       5
// mode control register fields
`define RSL_MODE_AN_BIT   0
`define RSL_MODE_SPD_BIT  1
`define RSL_MODE_DPX_BIT  2
`define RSL_MODE_STR_LSB  4
`define RSL_MODE_STR_MSB  6
// advertisement register fields
`define RSL_ADV_10H       0
`define RSL_ADV_10F       1
`define RSL_ADV_100H      2
`define RSL_ADV_100F      3
// status register fields
`define RSL_STAT_DONE     0
`define RSL_STAT_ISO      1

// strap defaults and decode codes
`define RSL_STRAP_DEF     3'h7
`define RSL_SEL_00        2'h0
`define RSL_SEL_01        2'h1
`define RSL_SEL_10        2'h2
`define RSL_SEL_11        2'h3
`define RSL_ZERO_ADDR     5'h00

`endif

// file: src/rsl_sync.v
/*
  two-flop synchroniser for a bus of pin inputs.
  assumes: one clock; pins are asynchronous to it.
*/
`timescale 1ns/1ps
`default_nettype none
module rsl_sync #(
  parameter W = 8
) (
  input  wire         clock,
  input  wire         resetn,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] meta; // first stage, read only by dout

  // resets to zero; constants only under reset
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      meta <= {W{1'b0}};
      dout <= {W{1'b0}};
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
`default_nettype wire

// file: src/rsl_strap_latch.v
/*
  reset strap latch: samples the station address and mode straps at the
  first clock edge after hardware reset is released, keeps them, and shows them over apb.
  assumes: resetn is asynchronous active low and clock runs through reset;
  strap pins settle several cycles before reset is released.
*/
// The register offsets and the APB slave port are this design's own decisions.
// Contract
// R1: sample five address straps, keep station address
// R2: latched address readable in station control register
// R3: isolation only when strapped address is zero
// R4: strap high: autoneg, advertise selected capability
// R5: strap low: forced speed/duplex from mode selects
// R6: mode straps latched into mode and advertise
// R7: after reset hold values, never resample straps
// R8: unstrapped mode pins read as all ones
// R9: forced 00 is 10 half, fixed decode
`timescale 1ns/1ps
`default_nettype none
`include "rsl_map.vh"
module rsl_strap_latch (
  input  wire        clock,
  input  wire        resetn,
  input  wire [4:0]  station_address_strap,
  input  wire        autoneg_enable_strap,
  input  wire        mode_select_strap_hi,
  input  wire        mode_select_strap_lo,
  input  wire        strap_fitted_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg  [4:0]  station_address,
  output reg         isolate,
  output reg         autoneg_on,
  output reg         speed_100,
  output reg         full_duplex,
  output reg  [3:0]  advertise,
  output reg         strap_done
);

  // synchronised pins; strap_fitted_n low means mode pins floating
  wire [8:0] pins_s;
  rsl_sync #(.W(9)) u_sync (
    .clock  (clock),
    .resetn (resetn),
    .din    ({strap_fitted_n, autoneg_enable_strap,
              mode_select_strap_hi, mode_select_strap_lo,
              station_address_strap}),
    .dout   (pins_s)
  );

  // internal pull-ups win when no strap is fitted
  wire [2:0] mode_pins = pins_s[8] ? pins_s[7:5] : `RSL_STRAP_DEF; // R8

  // limitation: the synchroniser clears under reset, so the strap level
  // is the one seen at the first edge after release; the board must keep
  // the straps steady for a few cycles past release
  // reset is async: a release pulse lets us capture on the clock
  reg  [1:0] rel_sh;    // released-reset shift, constant under reset
  reg        latched;   // straps frozen at third edge after release
  reg  [4:0] addr_q;    // latched station address
  reg  [2:0] mode_q;    // latched {an, hi, lo}
  reg  [4:0] sw_addr;   // software-written address, no isolate effect

  // forced decode: {speed_100, full_duplex}
  function [1:0] forced_dec;
    input [1:0] sel;
    begin
      case (sel)
        `RSL_SEL_00: forced_dec = 2'h0; // R9
        `RSL_SEL_01: forced_dec = 2'h1;
        `RSL_SEL_10: forced_dec = 2'h2;
        default:     forced_dec = 2'h3;
      endcase
    end
  endfunction

  // only codes 00 and 01 offer both duplexes; 10 and 11 offer half only
  // advertised capability set {100f,100h,10f,10h}
  function [3:0] adv_dec;
    input [1:0] sel;
    begin
      case (sel)
        `RSL_SEL_00: adv_dec = 4'h3;
        `RSL_SEL_01: adv_dec = 4'hc;
        `RSL_SEL_10: adv_dec = 4'h1;
        default:     adv_dec = 4'h4;
      endcase
    end
  endfunction

  // strap capture: tracks pins up to the third edge after release, then freezes
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rel_sh  <= 2'h0;
      latched <= 1'b0;
      addr_q  <= `RSL_ZERO_ADDR;
      mode_q  <= `RSL_STRAP_DEF;
    end
    else
    begin
      rel_sh <= {rel_sh[0], 1'b1};
      // sync delay means the last value kept is the pin level at the first edge after release
      if (!latched)
      begin
        addr_q <= pins_s[4:0];  // R1
        mode_q <= mode_pins;    // R6
        if (rel_sh[1])
          latched <= 1'b1;      // R7
      end
    end
  end

  // registered so every top-level output comes straight from a flop
  // derived outputs, all registered
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      station_address <= `RSL_ZERO_ADDR;
      isolate         <= 1'b0;
      autoneg_on      <= 1'b1;
      speed_100       <= 1'b1;
      full_duplex     <= 1'b1;
      advertise       <= 4'h0;
      strap_done      <= 1'b0;
    end
    else
    begin
      strap_done      <= latched;
      station_address <= latched ? sw_addr : addr_q;
      // only the strapped address picks isolation, not sw_addr
      isolate <= latched && (addr_q == `RSL_ZERO_ADDR); // R3
      autoneg_on <= mode_q[2];
      // speed and duplex are forced only while autoneg is off; under
      // autoneg they sit low and the capability set goes out instead
      if (mode_q[2])
      begin
        advertise   <= adv_dec(mode_q[1:0]);           // R4
        speed_100   <= 1'b0;
        full_duplex <= 1'b0;
      end
      else
      begin
        advertise   <= 4'h0;
        {speed_100, full_duplex} <= forced_dec(mode_q[1:0]); // R5
      end
    end
  end

  // no wait states: pready is a registered copy of the setup phase, so
  // every transfer takes exactly one access cycle and read data shows
  // the registers as they stood at the setup edge
  // apb slave: zero wait, one access phase
  wire acc   = psel && penable;
  wire wr_st = acc && pwrite && (paddr == `RSL_OFF_STATION);
  wire known = (paddr == `RSL_OFF_STATION) || (paddr == `RSL_OFF_MODE) ||
               (paddr == `RSL_OFF_ADV) || (paddr == `RSL_OFF_STATUS);

  // kept apart from addr_q so a later software write of address zero
  // can never reach the isolation decode
  // software address copy, seeded from the strap at freeze
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      sw_addr <= `RSL_ZERO_ADDR;
    else if (!latched)
      sw_addr <= pins_s[4:0];
    else if (wr_st)
      sw_addr <= pwdata[`RSL_ADDR_W-1:0];
  end

  // read mux and handshake outputs
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable; // ready in the access cycle
      pslverr <= psel && !penable && !known;
      prdata  <= 32'h0;
      if (psel && !penable && !pwrite)
      begin
        case (paddr)
          `RSL_OFF_STATION:
          begin
            prdata[`RSL_ADDR_W-1:0] <= sw_addr; // R2
            prdata[`RSL_ISO_BIT]    <= isolate;
          end
          `RSL_OFF_MODE:
          begin
            prdata[`RSL_MODE_AN_BIT]  <= autoneg_on;
            prdata[`RSL_MODE_SPD_BIT] <= speed_100;
            prdata[`RSL_MODE_DPX_BIT] <= full_duplex;
            prdata[`RSL_MODE_STR_MSB:`RSL_MODE_STR_LSB] <= mode_q; // R6
          end
          `RSL_OFF_ADV:
          begin
            prdata[`RSL_ADV_100F:`RSL_ADV_10H] <= advertise;
            prdata[`RSL_MODE_STR_MSB:`RSL_MODE_STR_LSB] <= mode_q;
          end
          `RSL_OFF_STATUS:
          begin
            prdata[`RSL_STAT_DONE] <= strap_done;
            prdata[`RSL_STAT_ISO]  <= isolate;
          end
          default: prdata <= 32'h0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/rsl_strap_model.sv
/*
  board strap resistors on the strap latch pins.
  assumes: pins hold levels a few edges past reset, then act as leds.
*/
`timescale 1ns/1ps
`default_nettype none
module rsl_strap_model (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       fitted,   // mode resistors present
  input  wire logic [7:0] level,    // {addr, autoneg, hi, lo}
  output logic      [7:0] pins,
  output logic            fitted_n
);
  logic [2:0] age;  // edges since release
  // count edges after release, then cycle so led activity never stops
  always @(posedge clock or negedge resetn)
    if (!resetn)
      age <= 3'h0;
    else
      age <= (age == 3'h7) ? 3'h5 : age + 3'h1;
  assign fitted_n = fitted;
  // floating mode pins carry no level; the latch's own pull-up must win
  assign pins = (age < 3'h5) ? {level[7:3], fitted ? level[2:0] : 3'h0}
              : ~level ^ {8{age[0]}};  // led traffic, not straps
endmodule
`default_nettype wire

// file: testbench/rsl_strap_latch_chk.sv
/*
  port assertions for the strap latch.
  assumes: bound to every rsl_strap_latch instance.
*/
`timescale 1ns/1ps
`default_nettype none
module rsl_strap_latch_chk (
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic [4:0] station_address,
  input wire logic       isolate,
  input wire logic       autoneg_on,
  input wire logic       speed_100,
  input wire logic       full_duplex,
  input wire logic [3:0] advertise,
  input wire logic       strap_done
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // sync flops delay the freeze a few edges
  sequence s_freeze;
    ##[2:5] strap_done;
  endsequence
  a_done_soon: assert property ($rose(resetn) |-> s_freeze)
    else $error("straps not frozen in time");
  a_done_stays: assert property (strap_done |=> strap_done)
    else $error("freeze flag dropped");
  a_held_after: assert property (strap_done && $past(strap_done) |->
    $stable({isolate, autoneg_on, speed_100, full_duplex, advertise}))
    else $error("latched mode changed");
  a_iso_strap: assert property ($rose(strap_done) |->
    isolate == (station_address == 5'h00)) else $error("isolate wrong");
  a_iso_late: assert property ($rose(isolate) |-> !$past(strap_done))
    else $error("isolate set after freeze");
  a_forced_adv: assert property (strap_done && !autoneg_on |->
    advertise == 4'h0) else $error("forced mode advertises");
  a_an_adv: assert property (strap_done && autoneg_on |->
    advertise != 4'h0 && !speed_100 && !full_duplex)
    else $error("autoneg outputs wrong");
  a_ready_pulse: assert property (psel && !penable |=>
    pready ##1 !pready) else $error("ready not one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule
bind rsl_strap_latch rsl_strap_latch_chk u_chk (.clock, .resetn, .psel,
  .penable, .pready, .pslverr, .station_address, .isolate, .autoneg_on,
  .speed_100, .full_duplex, .advertise, .strap_done);
`default_nettype wire

// file: testbench/rsl_strap_latch_bench.sv
/*
  bench for the strap latch: strap sets, latched outputs, apb reads.
  assumes: strap model and checker compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module rsl_strap_latch_bench;
  logic        clock = 0, resetn = 0, fitted = 1;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  level = 8'h00, pins;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, iso, an, spd, dpx, done, fn;
  logic [4:0]  sta;
  logic [3:0]  adv;
  logic [32:0] q[$];  // expected {pslverr, prdata}
  int          n_mismatch = 0, total_checks = 0;
  always #5 clock = ~clock;
  rsl_strap_model u_pull (.clock, .resetn, .fitted, .level, .pins,
    .fitted_n(fn));
  rsl_strap_latch dut (.clock, .resetn, .station_address_strap(pins[7:3]),
    .autoneg_enable_strap(pins[2]), .mode_select_strap_hi(pins[1]),
    .mode_select_strap_lo(pins[0]), .strap_fitted_n(fn), .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .station_address(sta), .isolate(iso), .autoneg_on(an), .speed_100(spd),
    .full_duplex(dpx), .advertise(adv), .strap_done(done));
  task check(input logic [32:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %0t %h %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    if (n_mismatch == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // advertised caps per autoneg strap code
  function logic [3:0] cap(input logic [2:0] m);
    case (m)
      3'h4: cap = 4'h3;
      3'h5: cap = 4'hc;
      3'h6: cap = 4'h1;
      3'h7: cap = 4'h4;
      default: cap = 4'h0;
    endcase
  endfunction
  // one apb transfer; reads leave their expectation on the queue
  task apb(input logic w, input logic [11:0] a, input logic [32:0] e);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= e[31:0];
    if (!w)
      q.push_back(e);
    @(posedge clock);
    penable <= 1;
    @(posedge clock);
    while (pready !== 1)
      @(posedge clock);
    psel <= 0;
    penable <= 0;
    @(posedge clock);
  endtask
  // read monitor
  always @(posedge clock)
    if (pready === 1 && !pwrite)
      check({pslverr, prdata}, q.pop_front());
  initial
  begin
    logic [2:0] m;
    logic [4:0] a;
    logic [4:0] w;
    logic       z;
    void'($urandom(31));
    for (int i = 0; i < 9; i++)
    begin
      a = (i == 0) ? 5'h00 : 5'($urandom);
      z = (a == 5'h00);
      w = i[0] ? 5'h00 : ~a;  // odd runs write zero, which must not isolate
      m = i[2:0];
      fitted <= (i != 8);
      level <= {a, m};
      if (i == 8)
        m = 3'h7;
      resetn <= 0;
      repeat (3) @(posedge clock);
      resetn <= 1;
      while (done !== 1)
        @(posedge clock);
      repeat (8) @(posedge clock);  // pins toggle as leds meanwhile
      check({iso, an, spd, dpx, sta, adv}, {z, m[2], ~m[2] & m[1],
        ~m[2] & m[0], a, cap(m)});
      apb(0, 12'h000, {27'h0, z, a});
      apb(0, 12'h004, {26'h0, m, 1'b0, ~m[2] & m[0], ~m[2] & m[1], m[2]});
      apb(0, 12'h008, {26'h0, m, cap(m)});
      apb(0, 12'h00c, {31'h0, z, 1'b1});
      apb(0, 12'h010, {1'b1, 32'h0});
      apb(1, 12'h000, {28'h0, w});
      apb(0, 12'h000, {27'h0, z, w});
      check({iso, sta}, {z, w});
    end
    stop_test;
  end
  // hang guard
  initial
  begin
    #20000;
    n_mismatch++;
    stop_test;
  end
endmodule
`default_nettype wire
